// *** verilog/diagnostic_history_logger.sv ***
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module diagnostic_history_logger (
  input  wire logic        clock,
  input  wire logic        reset,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // diagnostic event source
  input  wire logic        event_valid,
  input  wire logic [3:0]  event_severity,
  input  wire logic [15:0] event_text_reference,
  input  wire logic [1:0]  event_param_count,
  input  wire logic [11:0] event_param1_type,
  input  wire logic [63:0] event_param1_value,
  input  wire logic [11:0] event_param2_type,
  input  wire logic [63:0] event_param2_value,
  // environment and emergency path
  input  wire logic        temp_out_of_range,
  output logic             halt_state,
  output logic             new_messages,
  output logic             emcy_valid,
  output logic [255:0]     emcy_record,
  input  wire logic        emcy_ready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    diag_pkg::record_t [diag_pkg::DEPTH-1:0] mem;
    logic [diag_pkg::PTR_W-1:0]             wr_ptr;
    logic [7:0]                             newest;
    logic [7:0]                             acked;
    logic                                   new_avail;
    logic [15:0]                            fwd_flags;
    logic [3:0]                             filter;
    logic [31:0]                            ts_hi_snap;
    logic                                   aw_held;
    logic [11:0]                            aw_addr;
    logic                                   w_held;
    logic [31:0]                            w_data;
    logic [3:0]                             w_strb;
    logic                                   bvalid;
    logic [1:0]                             bresp;
    logic                                   rvalid;
    logic [31:0]                            rdata;
    logic [1:0]                             rresp;
    logic                                   temp_meta;
    logic                                   temp_sync;
    logic                                   halted;
    logic                                   emcy_valid;
    diag_pkg::record_t                      emcy_record;
  } state_t;

  state_t                     state_q;
  state_t                     state_d;
  logic [63:0]                now_ns;
  logic                       store;
  logic [3:0]                 rec_sev;
  logic                       sev_blocked;
  logic [diag_pkg::PTR_W-1:0] newest_slot;
  logic [11:0]                last_word_addr;
  logic [11:0]                msg_off;
  logic [31:0]                rd_data;
  logic [1:0]                 rd_resp;
  logic                       do_write;
  logic                       do_read;

  record_if rec ();

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  ns_timebase u_timebase (
    .clock  (clock),
    .reset  (reset),
    .now_ns (now_ns)
  );

  record_builder u_builder (
    .clock                (clock),
    .reset                (reset),
    .event_valid          (event_valid),
    .event_severity       (event_severity),
    .event_text_reference (event_text_reference),
    .event_param_count    (event_param_count),
    .event_param1_type    (event_param1_type),
    .event_param1_value   (event_param1_value),
    .event_param2_type    (event_param2_type),
    .event_param2_value   (event_param2_value),
    .now_ns               (now_ns),
    .rec                  (rec)
  );

  // byte-lane merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    merge = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) merge[8*b +: 8] = new_v[8*b +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    msg_off = s_axi_araddr - diag_pkg::A_MSG_BASE;
    rd_data = 32'h0000_0000;
    rd_resp = diag_pkg::RESP_OKAY;
    // 64 records of 32 bytes need 2 kbyte, so the window spans two address quarters
    if (s_axi_araddr >= diag_pkg::A_MSG_BASE && s_axi_araddr < diag_pkg::A_MSG_END) begin
      rd_data = state_q.mem[msg_off[10:5]][32*msg_off[4:2] +: 32];
    end else begin
      unique case ({s_axi_araddr[11:2], 2'b00})
        diag_pkg::A_MAX_MSG:   rd_data = {24'h000000, diag_pkg::MAX_MESSAGES};
        diag_pkg::A_NEWEST:    rd_data = {24'h000000, state_q.newest};
        diag_pkg::A_ACKED:     rd_data = {24'h000000, state_q.acked};
        diag_pkg::A_NEW_AVAIL: rd_data = {31'h0000_0000, state_q.new_avail};
        diag_pkg::A_FWD_FLAGS: rd_data = {16'h0000, state_q.fwd_flags};
        diag_pkg::A_FILTER:    rd_data = {28'h000_0000, state_q.filter};
        diag_pkg::A_TS_LO:     rd_data = now_ns[31:0];
        diag_pkg::A_TS_HI:     rd_data = state_q.ts_hi_snap;
        diag_pkg::A_STATUS:    rd_data = {31'h0000_0000, state_q.halted};
        default:               rd_resp = diag_pkg::RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d        = state_q;
    rec_sev        = rec.record[diag_pkg::FLAGS_LSB + diag_pkg::SEV_LSB +: 4];
    // filter bit 3 (overwrite/acknowledge mode) is stored but steers nothing
    sev_blocked    = (rec_sev == diag_pkg::SEV_INFO  && state_q.filter[0]) ||
                     (rec_sev == diag_pkg::SEV_WARN  && state_q.filter[1]) ||
                     (rec_sev == diag_pkg::SEV_ERROR && state_q.filter[2]);
    store          = rec.valid && !sev_blocked;
    newest_slot    = diag_pkg::PTR_W'(state_q.newest - diag_pkg::SUB_FIRST_MSG);
    last_word_addr = diag_pkg::A_MSG_BASE + {1'b0, newest_slot, diag_pkg::A_LAST_WORD};
    do_write       = state_q.aw_held && state_q.w_held && !state_q.bvalid;
    do_read        = s_axi_arvalid && !state_q.rvalid;

    // temperature pin through two flops, halt is held until reset
    state_d.temp_meta = temp_out_of_range;
    state_d.temp_sync = state_q.temp_meta;
    if (state_q.temp_sync) begin
      state_d.halted = 1'b1;
    end

    // write address and data are taken independently
    if (s_axi_awvalid && !state_q.aw_held && !state_q.bvalid) begin
      state_d.aw_held = 1'b1;
      state_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_q.w_held && !state_q.bvalid) begin
      state_d.w_held = 1'b1;
      state_d.w_data = s_axi_wdata;
      state_d.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      state_d.aw_held = 1'b0;
      state_d.w_held  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = diag_pkg::RESP_OKAY;
      unique case ({state_q.aw_addr[11:2], 2'b00})
        diag_pkg::A_ACKED: begin
          state_d.acked = 8'(merge({24'h000000, state_q.acked}, state_q.w_data, state_q.w_strb));
        end
        diag_pkg::A_FWD_FLAGS: begin
          // startup writes 0x0001 here to turn on forwarding
          state_d.fwd_flags = 16'(merge({16'h0000, state_q.fwd_flags}, state_q.w_data, state_q.w_strb));
        end
        diag_pkg::A_FILTER: begin
          state_d.filter = 4'(merge({28'h000_0000, state_q.filter}, state_q.w_data, state_q.w_strb));
        end
        // read-only entries accept the write and keep their value
        diag_pkg::A_MAX_MSG, diag_pkg::A_NEWEST, diag_pkg::A_NEW_AVAIL,
        diag_pkg::A_TS_LO, diag_pkg::A_TS_HI, diag_pkg::A_STATUS: begin
        end
        default: begin
          state_d.bresp = diag_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end

    // read answer one cycle after the address is taken
    if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
    if (do_read) begin
      state_d.rvalid = 1'b1;
      state_d.rdata  = rd_data;
      state_d.rresp  = rd_resp;
      // low half read freezes the high half so the pair is coherent
      if ({s_axi_araddr[11:2], 2'b00} == diag_pkg::A_TS_LO) begin
        state_d.ts_hi_snap = now_ns[63:32];
      end
      // last word of the newest record ends a whole-object read
      if ({s_axi_araddr[11:2], 2'b00} == last_word_addr && state_q.newest != 8'h00) begin
        state_d.new_avail = 1'b0;
      end
    end

    // storage, after the clear so that a new record keeps the flag set
    if (store) begin
      state_d.mem[state_q.wr_ptr] = rec.record;
      state_d.newest              = diag_pkg::SUB_FIRST_MSG + 8'(state_q.wr_ptr);
      state_d.wr_ptr              = state_q.wr_ptr + 1'b1;
      state_d.new_avail           = 1'b1;
    end

    // emergency copy; an unread one is replaced by the newer record
    if (state_q.emcy_valid && emcy_ready) begin
      state_d.emcy_valid = 1'b0;
    end
    if (store && state_q.fwd_flags == diag_pkg::FWD_ENABLE) begin
      state_d.emcy_valid  = 1'b1;
      state_d.emcy_record = rec.record;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !state_q.aw_held && !state_q.bvalid;
  assign s_axi_wready  = !state_q.w_held && !state_q.bvalid;
  assign s_axi_bvalid  = state_q.bvalid;
  assign s_axi_bresp   = state_q.bresp;
  assign s_axi_arready = !state_q.rvalid;
  assign s_axi_rvalid  = state_q.rvalid;
  assign s_axi_rdata   = state_q.rdata;
  assign s_axi_rresp   = state_q.rresp;
  assign halt_state    = state_q.halted;
  assign new_messages  = state_q.new_avail;
  assign emcy_valid    = state_q.emcy_valid;
  assign emcy_record   = state_q.emcy_record;

endmodule // diagnostic_history_logger

// *** verilog/diag_pkg.sv ***
package diag_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_PERIOD_NS = 25;
  localparam logic [63:0] NS_PER_CYCLE    = 64'(CLOCK_PERIOD_NS);

  // ----------------------------------------------------------------
  // record layout, bit positions within a 32-byte record
  // ----------------------------------------------------------------
  localparam int REC_BITS    = 256;
  localparam int DEPTH       = 64;
  localparam int PTR_W       = 6;
  localparam int FLAGS_LSB   = 32;
  localparam int TEXT_LSB    = 48;
  localparam int TS_LSB      = 64;
  localparam int PARAM_LSB   = 128;
  localparam int PARAM_BYTES = 16;
  localparam logic [31:0] EVENT_CODE = 32'h0000e000;
  typedef logic [REC_BITS-1:0] record_t;

  // flags word fields
  localparam int SEV_LSB      = 0;
  localparam int LOCAL_TS_BIT = 4;
  localparam int PCOUNT_LSB   = 8;
  localparam logic [3:0] SEV_INFO  = 4'h0;
  localparam logic [3:0] SEV_WARN  = 4'h1;
  localparam logic [3:0] SEV_ERROR = 4'h2;

  // parameter data type codes
  localparam logic [11:0] T_BOOL   = 12'h001;
  localparam logic [11:0] T_INT8   = 12'h002;
  localparam logic [11:0] T_INT16  = 12'h003;
  localparam logic [11:0] T_INT32  = 12'h004;
  localparam logic [11:0] T_UINT8  = 12'h005;
  localparam logic [11:0] T_UINT16 = 12'h006;
  localparam logic [11:0] T_UINT32 = 12'h007;
  localparam logic [11:0] T_REAL32 = 12'h008;
  localparam logic [11:0] T_REAL64 = 12'h011;
  localparam logic [11:0] T_INT64  = 12'h015;
  localparam logic [11:0] T_UINT64 = 12'h01b;

  // ----------------------------------------------------------------
  // history object entries and register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  SUB_FIRST_MSG = 8'h06;
  localparam logic [7:0]  MAX_MESSAGES  = 8'h40;
  localparam logic [15:0] FWD_ENABLE    = 16'h0001;
  localparam logic [11:0] A_MAX_MSG   = 12'h000;
  localparam logic [11:0] A_NEWEST    = 12'h004;
  localparam logic [11:0] A_ACKED     = 12'h008;
  localparam logic [11:0] A_NEW_AVAIL = 12'h00c;
  localparam logic [11:0] A_FWD_FLAGS = 12'h010;
  localparam logic [11:0] A_FILTER    = 12'h014;
  localparam logic [11:0] A_TS_LO     = 12'h018;
  localparam logic [11:0] A_TS_HI     = 12'h01c;
  localparam logic [11:0] A_STATUS    = 12'h020;
  localparam logic [11:0] A_MSG_BASE  = 12'h400;
  localparam logic [11:0] A_MSG_END   = 12'hc00;
  localparam logic [4:0]  A_LAST_WORD = 5'h1c;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // value size in bytes for a type code, 0 for unknown codes
  function automatic logic [3:0] type_size(input logic [11:0] code);
    unique case (code)
      T_BOOL, T_INT8, T_UINT8:            type_size = 4'h1;
      T_INT16, T_UINT16:                  type_size = 4'h2;
      T_INT32, T_UINT32, T_REAL32:        type_size = 4'h4;
      T_REAL64, T_INT64, T_UINT64:        type_size = 4'h8;
      default:                            type_size = 4'h0;
    endcase
  endfunction

endpackage

// *** verilog/record_if.sv ***
`timescale 1ns/1ps
interface record_if;
  logic                  valid;
  diag_pkg::record_t     record;

  modport producer (output valid, output record);
  modport consumer (input valid, input record);
endinterface

// *** verilog/ns_timebase.sv ***
`timescale 1ns/1ps
module ns_timebase (
  input  wire logic        clock,
  input  wire logic        reset,
  output logic      [63:0] now_ns
);
  typedef struct packed {
    logic [63:0] ns;
  } tb_state_t;

  tb_state_t state_q;
  tb_state_t state_d;

  // ----------------------------------------------------------------
  // nanoseconds since reset, one period per clock
  // ----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    state_d.ns = state_q.ns + diag_pkg::NS_PER_CYCLE;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign now_ns = state_q.ns;
endmodule // ns_timebase

// *** verilog/record_builder.sv ***
`timescale 1ns/1ps
module record_builder (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        event_valid,
  input  wire logic [3:0]  event_severity,
  input  wire logic [15:0] event_text_reference,
  input  wire logic [1:0]  event_param_count,
  input  wire logic [11:0] event_param1_type,
  input  wire logic [63:0] event_param1_value,
  input  wire logic [11:0] event_param2_type,
  input  wire logic [63:0] event_param2_value,
  input  wire logic [63:0] now_ns,
  record_if.producer       rec
);
  typedef struct packed {
    logic              valid;
    diag_pkg::record_t record;
  } rb_state_t;

  rb_state_t  state_q;
  rb_state_t  state_d;
  logic [127:0] area;
  logic [15:0]  flags;
  logic [4:0]   pos;
  logic [3:0]   n1;
  logic [3:0]   n2;
  logic [7:0]   stored;

  // ----------------------------------------------------------------
  // pack flags and parameters, little-endian bytes
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    area    = '0;
    stored  = 8'h00;
    n1      = diag_pkg::type_size(event_param1_type);
    n2      = diag_pkg::type_size(event_param2_type);
    pos     = 5'd0;
    // a second value that does not fit in 16 bytes is dropped, count says so
    if (event_param_count != 2'd0 && n1 != 4'h0) begin
      area[15:0] = {4'h0, event_param1_type};
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < n1) area[16 + 8*i +: 8] = event_param1_value[8*i +: 8];
      end
      pos    = 5'd2 + 5'(n1);
      stored = 8'h01;
      if (event_param_count >= 2'd2 && n2 != 4'h0 && (pos + 5'd2 + 5'(n2)) <= 5'd16) begin
        area[8*pos +: 16] = {4'h0, event_param2_type};
        for (int i = 0; i < 8; i++) begin
          if (4'(i) < n2) area[8*(pos + 5'd2) + 8*i +: 8] = event_param2_value[8*i +: 8];
        end
        stored = 8'h02;
      end
    end
    flags = {stored, 3'b000, 1'b1, event_severity};
    // reserved severity codes never leave this block
    state_d.valid  = event_valid && (event_severity <= diag_pkg::SEV_ERROR);
    if (state_d.valid) begin
      state_d.record = {area, now_ns, event_text_reference, flags, diag_pkg::EVENT_CODE};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rec.valid  = state_q.valid;
  assign rec.record = state_q.record;
endmodule // record_builder

// *** dv/diag_logger_asserts.sv ***
`timescale 1ns/1ps
module diag_logger_asserts (
  input wire logic         clock,
  input wire logic         reset,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic         temp_out_of_range,
  input wire logic         halt_state,
  input wire logic         emcy_valid,
  input wire logic [255:0] emcy_record,
  input wire logic         emcy_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_temp_high;
    temp_out_of_range [*3];
  endsequence
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_emcy_hold: assert property (emcy_valid && !emcy_ready |=> emcy_valid)
    else $error("emergency dropped before ready");
  a_event_code: assert property (emcy_valid |-> emcy_record[31:0] == 32'h0000e000)
    else $error("event code wrong");
  a_flag_bits: assert property (emcy_valid |-> emcy_record[35:32] <= 4'h2 && emcy_record[39:36] == 4'h1)
    else $error("flags severity or timestamp bits wrong");
  a_halt_entry: assert property (s_temp_high |=> halt_state)
    else $error("halt not entered");
  a_halt_sticky: assert property (halt_state |=> halt_state)
    else $error("halt left without reset");
endmodule // diag_logger_asserts

// *** dv/mailbox_master.sv ***
`timescale 1ns/1ps
module mailbox_master (
  input  wire logic        clock,
  output logic      [11:0] s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [11:0] s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
  end
  // taken lines get inverted so a late sample cannot see a stale match
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ta, tw, tb;
    bq.push_back(r);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clock);
      if (ta) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (tw) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ta, tr;
    rq.push_back({r, d});
    @(posedge clock);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge clock);
      if (ta) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    end while (!tr);
    s_axi_rready <= 1'b0;
  endtask
  always @(negedge clock) begin
    if (s_axi_rvalid && s_axi_rready) tb_diagnostic_history_logger.check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) tb_diagnostic_history_logger.check("bresp", s_axi_bresp, bq.pop_front());
  end
endmodule // mailbox_master

// *** dv/tb_diagnostic_history_logger.sv ***
`timescale 1ns/1ps
module tb_diagnostic_history_logger;
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic [11:0]  s_axi_awaddr, s_axi_araddr, event_param1_type, event_param2_type;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb, event_severity;
  logic [1:0]   s_axi_bresp, s_axi_rresp, event_param_count;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, event_valid;
  logic [15:0]  event_text_reference;
  logic [63:0]  event_param1_value, event_param2_value;
  logic         temp_out_of_range = 1'b0;
  logic         emcy_ready = 1'b1;
  logic         halt_state, new_messages, emcy_valid;
  logic [255:0] emcy_record, last, e, eq[$];
  logic [2:0]   filt = 3'h0;
  int           fails, checked, tmo, cyc, nst, slot;
  logic [11:0]  codes[11] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h007, 12'h008,
                            12'h011, 12'h015, 12'h01b};
  initial {event_valid, event_severity, event_text_reference, event_param_count} = '0;
  initial {event_param1_type, event_param1_value, event_param2_type, event_param2_value} = '0;
  mailbox_master m (.*);
  diagnostic_history_logger dut (.*);
  initial begin
    forever #12.5 clock = ~clock;
  end
  always @(negedge clock) cyc <= cyc + 1;
  always @(posedge clock) begin
    tmo <= tmo + 1;
    if (tmo == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic check(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic int sz(input logic [11:0] t);
    case (t)
      12'h001, 12'h002, 12'h005: return 1;
      12'h003, 12'h006: return 2;
      12'h004, 12'h007, 12'h008: return 4;
      default: return 8;
    endcase
  endfunction
  // 25 ns per edge after the reset edge; the event is taken one edge after the drive
  function automatic logic [255:0] mk(input logic [3:0] s, input logic [15:0] tx, input logic [1:0] c,
                                      input logic [11:0] a, input logic [63:0] x, input logic [11:0] b,
                                      input logic [63:0] y);
    logic [127:0] p;
    int           n1, n2;
    logic [7:0]   k;
    n1 = sz(a);
    n2 = sz(b);
    k = (c == 2'h0) ? 8'h00 : (c == 2'h1 || 4 + n1 + n2 > 16) ? 8'h01 : 8'h02;
    p = '0;
    if (k > 0) p = 128'(a) | (128'(x & ~(64'hffffffffffffffff << (8 * n1))) << 16);
    if (k > 1) p = p | (128'(b) << (16 + 8 * n1)) | (128'(y & ~(64'hffffffffffffffff << (8 * n2))) << (32 + 8 * n1));
    return {p, 64'(cyc - 4) * 64'h19, tx, k, 3'h0, 1'b1, s, 32'h0000e000};
  endfunction
  task automatic ev(input logic [3:0] s, input logic [1:0] c, input logic [11:0] a);
    logic [11:0] b;
    logic [63:0] x, y;
    logic [15:0] tx;
    b = codes[$urandom % 11];
    x = {$urandom, $urandom};
    y = {$urandom, $urandom};
    tx = 16'($urandom);
    @(posedge clock);
    {event_valid, event_severity, event_text_reference, event_param_count} <= {1'b1, s, tx, c};
    {event_param1_type, event_param1_value, event_param2_type, event_param2_value} <= {a, x, b, y};
    if (s <= 4'h2 && !filt[s[1:0]]) begin
      last = mk(s, tx, c, a, x, b, y);
      eq.push_back(last);
      nst++;
    end
  endtask
  task automatic idle();
    @(posedge clock);
    event_valid <= 1'b0;
  endtask
  always @(negedge clock) begin
    if (!reset && emcy_valid && emcy_ready) begin
      e = (eq.size() > 0) ? eq.pop_front() : '0;
      check("emergency record", emcy_record, e);
    end
  end
  initial begin
    void'($urandom(32'h0041));
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    m.rd(12'h000, 32'h40, 2'h0);
    m.rd(12'h004, 32'h0, 2'h0);
    m.rd(12'h008, 32'h0, 2'h0);
    m.rd(12'h00c, 32'h0, 2'h0);
    m.rd(12'h3fc, 32'h0, 2'h2);
    m.wr(12'h3fc, 32'h5, 2'h2);
    m.wr(12'h008, 32'h12, 2'h0);
    m.rd(12'h008, 32'h12, 2'h0);
    m.wr(12'h010, 32'h1, 2'h0);
    for (int s = 0; s < 4; s++) ev(4'(s), 2'(s % 3), codes[s]);
    for (int i = 0; i < 11; i++) ev(4'h2, 2'h2, codes[i]);
    idle();
    m.wr(12'h014, 32'h2, 2'h0);
    filt = 3'h2;
    for (int s = 0; s < 3; s++) ev(4'(s), 2'h1, codes[s]);
    idle();
    m.wr(12'h014, 32'h8, 2'h0);
    filt = 3'h0;
    while (nst < 66) ev(4'($urandom % 3), 2'($urandom % 3), codes[$urandom % 11]);
    idle();
    repeat (3) @(posedge clock);
    check("emergency queue", eq.size(), 0);
    slot = (nst - 1) % 64;
    m.rd(12'h004, 32'(6 + slot), 2'h0);
    m.rd(12'h400 + 12'(slot * 32), 32'h0000e000, 2'h0);
    check("pending", new_messages, 1'b1);
    m.rd(12'h41c + 12'(slot * 32), last[255:224], 2'h0);
    check("pending", new_messages, 1'b0);
    temp_out_of_range <= 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    check("halt", halt_state, 1'b1);
    m.rd(12'h020, 32'h1, 2'h0);
    // address is taken two edges after this call is made
    m.rd(12'h018, 32'((cyc - 3) * 25), 2'h0);
    m.rd(12'h01c, 32'h0, 2'h0);
    report_and_stop();
  end
endmodule // tb_diagnostic_history_logger

bind diagnostic_history_logger diag_logger_asserts chk (.clock, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .temp_out_of_range, .halt_state, .emcy_valid, .emcy_record,
  .emcy_ready);
